/* logic/dac_cmd_pkg.sv */
// Constants and types shared by the quad DAC command port
package dac_cmd_pkg;
    localparam int         WORD_W        = 24;
    localparam int         CODE_W        = 16;
    localparam int         NCH           = 4;
    localparam int         OP_HI         = 23;
    localparam int         OP_LO         = 20;
    localparam int         SEL_HI        = 19;
    localparam int         SEL_LO        = 16;
    localparam int         DATA_HI       = 15;
    localparam int         DATA_LO       = 0;
    localparam int         RES_BITS      = 16;
    localparam logic [6:0] ADDR_MASK_HI  = 7'h7C;
    localparam logic [6:0] ADDR_FIXED    = 7'h0C;
    localparam logic [3:0] OP_NOP        = 4'h0;
    localparam logic [3:0] OP_WR_IN      = 4'h1;
    localparam logic [3:0] OP_UPD        = 4'h2;
    localparam logic [3:0] OP_WR_UPD     = 4'h3;
    localparam logic [3:0] OP_PWR        = 4'h4;
    localparam logic [3:0] OP_MASK       = 4'h5;
    localparam logic [3:0] OP_SWRST      = 4'h6;
    localparam logic [3:0] OP_REF        = 4'h7;
    localparam logic [15:0] CODE_RST     = 16'h0000;
    localparam logic [7:0] PWR_RST       = 8'h00;
    localparam logic [3:0] MASK_RST      = 4'h0;
    localparam logic       REF_OFF_RST   = 1'b0;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [1:0] BYTE_LAST     = 2'h3;
    localparam real        SCL_FAST_KHZ  = 400.0;
    localparam real        SYS_MHZ       = 100.0;
    localparam int         SCL_HALF_MIN  = int'((SYS_MHZ * 1000.0) / (2.0 * SCL_FAST_KHZ));
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_DATA, ST_DACK, ST_IGN} i2c_st_t;
endpackage

/* logic/cmd_word_if.sv */
// Carries an assembled command word from the serial front end
`timescale 1ns/1ps
interface cmd_word_if;
    import dac_cmd_pkg::*;
    logic [WORD_W-1:0] word;
    logic              valid;
    modport src (output word, output valid);
    modport dst (input word, input valid);
endinterface

/* logic/i2c_word_rx.sv */
// I2C slave receiver that assembles 24-bit write words
`timescale 1ns/1ps
module i2c_word_rx
    import dac_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst,
    // Synchronised bus lines and strap
    input  wire logic   scl_s,
    input  wire logic   sda_s,
    input  wire logic [1:0] addr_strap,
    // Acknowledge drive
    output logic        sda_oe,
    // Word out
    cmd_word_if.src     cw
);
    i2c_st_t           st_r;
    logic              scl_d_r;
    logic              sda_d_r;
    logic [7:0]        sh_r;
    logic [2:0]        bit_r;
    logic [1:0]        byte_r;
    logic [WORD_W-1:0] word_r;
    logic              valid_r;
    logic              ack_r;
    logic              got_rise_r;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_c;
    logic              stop_c;
    logic [7:0]        byte_in;

    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign byte_in  = {sh_r[6:0], sda_s};
    assign sda_oe   = ack_r;
    assign cw.word  = word_r;
    assign cw.valid = valid_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Bits are sampled while SCL is high; shifting completes at the falling edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r    <= ST_IDLE;
            sh_r    <= 8'h00;
            bit_r   <= 3'h0;
            byte_r  <= 2'h0;
            word_r  <= '0;
            valid_r    <= 1'b0;
            ack_r      <= 1'b0;
            got_rise_r <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            if (start_c) begin
                st_r       <= ST_ADDR;
                bit_r      <= 3'h0;
                ack_r      <= 1'b0;
                got_rise_r <= 1'b0;
            end else if (stop_c) begin
                st_r  <= ST_IDLE;
                ack_r <= 1'b0;
            end else begin
                case (st_r)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            sh_r       <= byte_in;
                            got_rise_r <= 1'b1;
                        end
                        // The SCL fall that closes a START carries no bit
                        if (scl_fall && got_rise_r) begin
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == BIT_LAST) begin
                                // 7-bit write only; general call and 10-bit never match
                                if ((sh_r[7:1] & ADDR_MASK_HI) == ADDR_FIXED
                                    && sh_r[2:1] == addr_strap && !sh_r[0]) begin
                                    st_r   <= ST_AACK;
                                    ack_r  <= 1'b1;
                                    byte_r <= 2'h0;
                                end else begin
                                    st_r <= ST_IGN;
                                end
                            end
                        end
                    end
                    ST_AACK, ST_DACK: begin
                        if (scl_fall) begin
                            ack_r <= 1'b0;
                            bit_r <= 3'h0;
                            st_r  <= ST_DATA;
                            if (byte_r == BYTE_LAST) begin
                                byte_r <= 2'h0;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (scl_rise) begin
                            sh_r <= byte_in;
                        end
                        if (scl_fall) begin
                            bit_r <= bit_r + 3'h1;
                            word_r <= {word_r[WORD_W-2:0], sh_r[0]};
                            if (bit_r == BIT_LAST) begin
                                st_r   <= ST_DACK;
                                ack_r  <= 1'b1;
                                byte_r <= byte_r + 2'h1;
                                if (byte_r == 2'h2) begin
                                    valid_r <= 1'b1;
                                    byte_r  <= BYTE_LAST;
                                end
                            end
                        end
                    end
                    ST_IGN: ack_r <= 1'b0;
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* logic/quad_dac_i2c_command_port.sv */
// Command port of a quad voltage-output DAC behind an I2C slave
`timescale 1ns/1ps
module quad_dac_i2c_command_port
    import dac_cmd_pkg::*;
#(
    parameter int RES = RES_BITS
)
(
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // I2C pins
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe,
    // Straps and strobes
    input  wire logic [1:0]              addr_pin,
    input  wire logic                    gain_pin,
    input  wire logic                    load_strobe_n,
    // Analog-side controls
    output logic [NCH-1:0][CODE_W-1:0]   dac_code,
    output logic [NCH-1:0][1:0]          pwr_mode,
    output logic                         ref_enable,
    output logic                         gain_two
);
    logic              scl_m_r, scl_s_r;
    logic              sda_m_r, sda_s_r;
    logic              ld_m_r, ld_s_r;
    logic              gn_m_r, gn_s_r;
    logic [1:0]        a_m_r, a_s_r;
    logic [1:0]        strap_r;
    logic              strap_done_r;
    logic [1:0]        strap_vld_r;
    logic [NCH-1:0][CODE_W-1:0] in_reg_r;
    logic [NCH-1:0][CODE_W-1:0] dac_reg_r;
    logic [7:0]        pwr_r;
    logic [NCH-1:0]    mask_r;
    logic              ref_off_r;
    logic              gain_r;
    logic [3:0]        op;
    logic [NCH-1:0]    sel;
    logic [CODE_W-1:0] code;
    logic              wr_in;
    logic              upd;
    logic              swrst;
    cmd_word_if        cw ();

    // Two-stage synchronisers on all pin inputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            ld_m_r  <= 1'b1;
            ld_s_r  <= 1'b1;
            gn_m_r  <= 1'b0;
            gn_s_r  <= 1'b0;
            a_m_r   <= 2'h0;
            a_s_r   <= 2'h0;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            ld_m_r  <= load_strobe_n;
            ld_s_r  <= ld_m_r;
            gn_m_r  <= gain_pin;
            gn_s_r  <= gn_m_r;
            a_m_r   <= addr_pin;
            a_s_r   <= a_m_r;
        end
    end

    // The address strap is latched once, after the synchroniser holds real pin values
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_r      <= 2'h0;
            strap_vld_r  <= 2'h0;
            strap_done_r <= 1'b0;
        end else begin
            strap_vld_r <= {strap_vld_r[0], 1'b1};
            if (strap_vld_r[1] && !strap_done_r) begin
                strap_r      <= a_s_r;
                strap_done_r <= 1'b1;
            end
        end
    end

    // Sampling at 100 MHz leaves ample margin for 400 kHz SCL
    i2c_word_rx u_rx (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .scl_s      (scl_s_r),
        .sda_s      (sda_s_r),
        .addr_strap (strap_r),
        .sda_oe     (sda_oe),
        .cw         (cw)
    );
    assign sda_out = 1'b0;

    assign op    = cw.word[OP_HI:OP_LO];
    assign sel   = cw.word[SEL_HI:SEL_LO];
    // Bits below the resolution are dropped, keeping MSB alignment
    assign code  = cw.word[DATA_HI:DATA_LO] & ~((CODE_W'(1) << (CODE_W - RES)) - CODE_W'(1));
    assign wr_in = cw.valid && (op == OP_WR_IN || op == OP_WR_UPD);
    assign upd   = cw.valid && (op == OP_UPD || op == OP_WR_UPD);
    assign swrst = cw.valid && op == OP_SWRST;

    // Input registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            in_reg_r <= {NCH{CODE_RST}};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (swrst) begin
                    in_reg_r[i] <= CODE_RST;
                end else if (wr_in && sel[i]) begin
                    in_reg_r[i] <= code;
                end
            end
        end
    end

    // DAC registers; write-with-update loads the new code directly
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dac_reg_r <= {NCH{CODE_RST}};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (swrst) begin
                    dac_reg_r[i] <= CODE_RST;
                end else if (upd && sel[i]) begin
                    dac_reg_r[i] <= (op == OP_WR_UPD) ? code : in_reg_r[i];
                end else if (!ld_s_r && !mask_r[i]) begin
                    dac_reg_r[i] <= in_reg_r[i];
                end
            end
        end
    end

    // Configuration state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwr_r     <= PWR_RST;
            mask_r    <= MASK_RST;
            ref_off_r <= REF_OFF_RST;
        end else if (swrst) begin
            pwr_r     <= PWR_RST;
            mask_r    <= MASK_RST;
            ref_off_r <= REF_OFF_RST;
        end else if (cw.valid) begin
            case (op)
                OP_PWR:  pwr_r     <= cw.word[7:0];
                OP_MASK: mask_r    <= cw.word[NCH-1:0];
                OP_REF:  ref_off_r <= cw.word[0];
                default: ;
            endcase
        end
    end

    // Gain strap tracked continuously; it is a tied pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gain_r <= 1'b0;
        end else begin
            gain_r <= gn_s_r;
        end
    end

    assign dac_code   = dac_reg_r;
    assign pwr_mode   = pwr_r;
    assign ref_enable = ~ref_off_r;
    assign gain_two   = gain_r;
endmodule

/* tb/i2c_master_model.sv */
// Behavioural I2C bus master that writes command words to the port
`timescale 1ns/1ps
module i2c_master_model (
    // Bus lines
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_bus
);
    int n_ack;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Low 75 ns, high 50 ns; data moves mid-low so no false START is seen
    task automatic bit_x(input logic b, output logic r);
        #25 sda_low = !b;
        #50 scl = 1'b1;
        #25 r = sda_bus;
        #25 scl = 1'b0;
    endtask
    // Plain 7-bit address, then command, high and low bytes
    task automatic xfer(input logic [7:0] a, input logic [23:0] w);
        logic        r;
        logic [31:0] s;
        s = {a, w};
        n_ack = 0;
        #25 sda_low = 1'b1;
        #50 scl = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            bit_x(s[i], r);
            if (i % 8 == 0) begin
                bit_x(1'b1, r);
                n_ack += int'(!r);
            end
        end
        #25 sda_low = 1'b1;
        #50 scl = 1'b1;
        #50 sda_low = 1'b0;
        #200;
    endtask
endmodule

/* tb/quad_dac_checker.sv */
// Concurrent checks on the pins of the quad DAC command port
`timescale 1ns/1ps
module quad_dac_checker
    import dac_cmd_pkg::*;
#(
    parameter int RES = RES_BITS
)
(
    // Clock, reset and bus
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic                  scl_in,
    input wire logic                  sda_in,
    input wire logic                  sda_out,
    input wire logic                  sda_oe,
    // Straps, strobe and outputs
    input wire logic [1:0]            addr_pin,
    input wire logic                  gain_pin,
    input wire logic                  load_strobe_n,
    input wire logic [NCH-1:0][CODE_W-1:0] dac_code,
    input wire logic [NCH-1:0][1:0]   pwr_mode,
    input wire logic                  ref_enable,
    input wire logic                  gain_two
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    reset_vals_a: assert property ($fell(rst) |-> ref_enable && dac_code == '0 && !sda_oe)
        else $error("outputs not at reset values");
    gain_follow_a: assert property ($stable(gain_pin) [*4] |-> gain_two == gain_pin)
        else $error("gain output does not follow pin");
    open_drain_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    ack_low_a: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("acknowledge raised while clock high");
    ack_hold_a: assert property (sda_oe && $rose(scl_in) |-> sda_oe [*4])
        else $error("acknowledge dropped during clock high");
    ack_release_a: assert property (sda_oe && $fell(scl_in) |-> ##[1:7] !sda_oe)
        else $error("acknowledge not released");
    // Idle bus with strobe high: nothing may move the DAC registers
    code_hold_a: assert property ((scl_in && load_strobe_n) [*8] |=> $stable(dac_code))
        else $error("DAC register moved while idle");
    cfg_hold_a: assert property (scl_in [*8] |=> $stable(ref_enable) && $stable(pwr_mode))
        else $error("configuration moved while idle");
    cover property ($rose(sda_oe));
    cover property ($fell(ref_enable));
    cover property (!load_strobe_n ##1 $changed(dac_code));
endmodule
bind quad_dac_i2c_command_port quad_dac_checker #(.RES(RES)) chk (.clk_sys(clk_sys),
    .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_pin(addr_pin), .gain_pin(gain_pin), .load_strobe_n(load_strobe_n),
    .dac_code(dac_code), .pwr_mode(pwr_mode), .ref_enable(ref_enable), .gain_two(gain_two));

/* tb/tb_quad_dac_i2c_command_port.sv */
// Self-checking bench for the quad DAC command port
`timescale 1ns/1ps
module tb_quad_dac_i2c_command_port;
    import dac_cmd_pkg::*;
    localparam int         RESN = 12;
    localparam logic [7:0] DEV  = {ADDR_FIXED[6:2], 2'b10, 1'b0};
    logic                       clk_sys, rst, scl, m_low, gain_pin, load_strobe_n;
    logic                       sda_out, sda_oe, ref_enable, gain_two, ref_e;
    logic [1:0]                 addr_pin;
    logic [NCH-1:0][CODE_W-1:0] dac_code;
    logic [NCH-1:0][1:0]        pwr_mode;
    logic [15:0]                in_e [NCH];
    logic [15:0]                dac_e [NCH];
    logic [7:0]                 pwr_e;
    logic [3:0]                 mask_e;
    logic [23:0]                w;
    int                         n_fail, n_tests, seed;
    // Pull-up: the line is high unless some party pulls it
    wire sda = !(m_low || (sda_oe && !sda_out));
    quad_dac_i2c_command_port #(.RES(RESN)) uut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin(addr_pin),
        .gain_pin(gain_pin), .load_strobe_n(load_strobe_n), .dac_code(dac_code),
        .pwr_mode(pwr_mode), .ref_enable(ref_enable), .gain_two(gain_two));
    i2c_master_model m (.scl(scl), .sda_low(m_low), .sda_bus(sda));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic void reset_e();
        for (int c = 0; c < NCH; c++) begin
            in_e[c] = CODE_RST;
            dac_e[c] = CODE_RST;
        end
        pwr_e = PWR_RST;
        mask_e = MASK_RST;
        ref_e = 1'b1;
    endfunction
    function automatic void apply(input logic [23:0] x);
        logic [3:0] op;
        op = x[OP_HI:OP_LO];
        for (int c = 0; c < NCH; c++) begin
            if (x[SEL_LO+c] && (op == OP_WR_IN || op == OP_WR_UPD)) begin
                in_e[c] = x[15:0] & ~(16'hFFFF >> RESN);
            end
            if (x[SEL_LO+c] && (op == OP_UPD || op == OP_WR_UPD)) begin
                dac_e[c] = in_e[c];
            end
        end
        if (op == OP_PWR) pwr_e = x[7:0];
        if (op == OP_MASK) mask_e = x[3:0];
        if (op == OP_REF) ref_e = !x[0];
        if (op == OP_SWRST) reset_e();
        for (int c = 0; c < NCH; c++) begin
            if (!load_strobe_n && !mask_e[c]) dac_e[c] = in_e[c];
        end
    endfunction
    task automatic check_all();
        for (int c = 0; c < NCH; c++) chk("dac_code", dac_e[c], dac_code[c]);
        chk("pwr_mode", {8'h00, pwr_e}, {8'h00, pwr_mode});
        chk("ref_enable", {15'h0000, ref_e}, {15'h0000, ref_enable});
    endtask
    task automatic send(input logic [7:0] a, input logic [23:0] x, input int acks);
        m.xfer(a, x);
        chk("ack count", 16'(acks), 16'(m.n_ack));
        if (acks == 4) apply(x);
        repeat (4) @(posedge clk_sys);
        check_all();
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        // 43 frames of under 500 cycles each; the limit is nearly twice that
        #400_000;
        n_fail++;
        wrap_up();
    end
    initial begin
        seed = 64;
        rst = 1'b1;
        gain_pin = 1'b0;
        load_strobe_n = 1'b1;
        addr_pin = 2'b10;
        n_fail = 0;
        n_tests = 0;
        reset_e();
        repeat (20) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk_sys);
        check_all();
        $display("Test reset done");
        // Every opcode once in order, then random words
        for (int i = 0; i < 36; i++) begin
            w = 24'($random(seed));
            if (i < 16) w[23:20] = 4'(i);
            send(DEV, w, 4);
        end
        $display("Test opcodes done");
        // Foreign strap, general call and read all stay unanswered
        send(DEV ^ 8'h04, {OP_WR_UPD, 4'hF, 16'hFFFF}, 0);
        send(8'h00, {OP_WR_UPD, 4'hF, 16'hFFFF}, 0);
        send(DEV | 8'h01, {OP_WR_UPD, 4'hF, 16'hFFFF}, 0);
        $display("Test addressing done");
        send(DEV, {OP_MASK, 4'h0, 16'h0002}, 4);
        send(DEV, {OP_WR_IN, 4'hF, 16'h5A5F}, 4);
        @(posedge clk_sys);
        #1 load_strobe_n = 1'b0;
        apply({OP_NOP, 20'h00000});
        repeat (8) @(posedge clk_sys);
        check_all();
        send(DEV, {OP_WR_IN, 4'h3, 16'hC3C1}, 4);
        @(posedge clk_sys);
        #1 load_strobe_n = 1'b1;
        send(DEV, {OP_UPD, 4'h2, 16'h0000}, 4);
        $display("Test strobe done");
        @(posedge clk_sys);
        #1 gain_pin = 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("gain_two", 16'h0001, {15'h0000, gain_two});
        $display("Test gain done");
        wrap_up();
    end
endmodule
